// *** gpio_pkg.sv ***
`default_nettype none

package gpio_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 16;
  localparam int unsigned PIN_N = 32;

  // register offsets, as byte addresses
  localparam logic [7:0] OFS_FSEL_LO = 8'h70;
  localparam logic [7:0] OFS_DIR_LO = 8'h72;
  localparam logic [7:0] OFS_LVL_LO = 8'h74;
  localparam logic [7:0] OFS_FSEL_HI = 8'h76;
  localparam logic [7:0] OFS_DIR_HI = 8'h78;
  localparam logic [7:0] OFS_LVL_HI = 8'h7a;

  // reset values
  localparam logic [15:0] RST_FSEL_LO = 16'h0000;
  localparam logic [15:0] RST_FSEL_HI = 16'h0000;
  localparam logic [15:0] RST_DIR_LO = 16'hfc0f;
  localparam logic [15:0] RST_DIR_HI = 16'hffff;
  // level latch has no defined reset value; zero is used so nothing floats
  localparam logic [15:0] RST_LVL = 16'h0000;
  localparam logic [15:0] RD_IDLE = 16'h0000;
  localparam logic [31:0] PIN_ZERO = 32'h0000_0000;

  // pins whose reset default is an active-high output; these pull down
  localparam logic [31:0] PULL_DOWN_MASK = 32'h0000_0000;

  // per-pin function, from the mode bit and the direction bit
  typedef enum logic [1:0] {
    GPIO_NORMAL,
    GPIO_IN_PULL,
    GPIO_OUTPUT,
    GPIO_IN_NOPULL
  } gpio_pin_fn_t;

endpackage

`default_nettype wire

// *** gpio_pins.sv ***
// What this block does
// - mode and direction bits together pick normal, pulled input, output, bare input.
// - after reset every pin is normal function or pulled input.
// - pins defaulting to active-high outputs pull down, all others pull up.
// - upper mode bits at 76h, reset 0000h, top bit is pin 31.
// - lower mode bits at 70h, reset 0000h, same bit ordering.
// - direction 1 means input; 0 means output or normal function.
// - upper direction bits at 78h, reset FFFFh, top bit is pin 31.
// - lower direction bits at 72h, reset FC0Fh.
// - direction and level bits map to pins exactly like mode bits.
// - output pins drive the stored level bit uninverted.
// - input pins read back the present pin level uninverted.
// - upper level bits at 7Ah, reset value undefined.
// - lower level bits at 74h, reset value undefined.
// - open drain by holding level constant and toggling the direction bit.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module gpio_pins (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  // normal pin functions of the surrounding peripherals
  input wire logic [31:0] func_out,
  input wire logic [31:0] func_oe,
  output logic [31:0] func_in,
  // pads
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] pull_up_en,
  output logic [31:0] pull_down_en
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // join a high and a low half so bit 31 is always pin 31
  function automatic logic [31:0] join_halves(input logic [15:0] hi, input logic [15:0] lo);
    join_halves = {hi, lo};
  endfunction

  // classify one pin from its mode and direction bit
  function automatic gpio_pkg::gpio_pin_fn_t pin_fn(input logic mode, input logic dir);
    pin_fn = gpio_pkg::gpio_pin_fn_t'({mode, dir});
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] fsel_lo_ff;
  logic [15:0] fsel_hi_ff;
  logic [15:0] dir_lo_ff;
  logic [15:0] dir_hi_ff;
  logic [15:0] lvl_lo_ff;
  logic [15:0] lvl_hi_ff;
  logic [15:0] rd_data_ff;
  logic [31:0] pin_out_ff;
  logic [31:0] pin_oe_ff;
  logic [31:0] pull_up_ff;
  logic [31:0] pull_dn_ff;
  logic [31:0] func_in_ff;

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  // one hit wire per register, printed offsets used as byte addresses
  wire hit_fsel_lo = (addr == gpio_pkg::OFS_FSEL_LO);
  wire hit_fsel_hi = (addr == gpio_pkg::OFS_FSEL_HI);
  wire hit_dir_lo = (addr == gpio_pkg::OFS_DIR_LO);
  wire hit_dir_hi = (addr == gpio_pkg::OFS_DIR_HI);
  wire hit_lvl_lo = (addr == gpio_pkg::OFS_LVL_LO);
  wire hit_lvl_hi = (addr == gpio_pkg::OFS_LVL_HI);

  //////////////////////////////////////////////////////////////////////////////
  // per-pin function decode

  // whole 32-pin views, same bit position means same pin in every pair
  wire [31:0] mode_all = join_halves(fsel_hi_ff, fsel_lo_ff);
  wire [31:0] dir_all = join_halves(dir_hi_ff, dir_lo_ff);
  wire [31:0] lvl_all = join_halves(lvl_hi_ff, lvl_lo_ff);

  wire [31:0] is_normal;
  wire [31:0] is_out;
  wire [31:0] is_in_pull;
  wire [31:0] is_in;

  genvar gi;
  generate
    for (gi = 0; gi < gpio_pkg::PIN_N; gi++) begin : g_pin
      // the two bits are read as one code, except is_in, which also takes the direction bit alone
      assign is_normal[gi] = (pin_fn(mode_all[gi], dir_all[gi]) == gpio_pkg::GPIO_NORMAL);
      assign is_out[gi] = (pin_fn(mode_all[gi], dir_all[gi]) == gpio_pkg::GPIO_OUTPUT);
      assign is_in_pull[gi] = (pin_fn(mode_all[gi], dir_all[gi]) == gpio_pkg::GPIO_IN_PULL);
      assign is_in[gi] = dir_all[gi] & ~is_normal[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // pad drive

  // output drives the level latch; normal mode hands the pad to the peripheral
  wire [31:0] nxt_pin_out = (is_out & lvl_all) | (is_normal & func_out);
  // with the mode bit set, direction alone gates the driver, which is what open-drain emulation uses
  wire [31:0] nxt_pin_oe = is_out | (is_normal & func_oe);
  // pulls only in the pulled-input code; polarity from the reset-default mask
  wire [31:0] nxt_pull_up = is_in_pull & ~gpio_pkg::PULL_DOWN_MASK;
  wire [31:0] nxt_pull_dn = is_in_pull & gpio_pkg::PULL_DOWN_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // input pins show the pad; other pins show what software stored
  wire [31:0] lvl_view = (is_in & pin_in) | (~is_in & lvl_all);
  wire [15:0] nxt_rd_data =
    hit_fsel_lo ? fsel_lo_ff :
    hit_fsel_hi ? fsel_hi_ff :
    hit_dir_lo ? dir_lo_ff :
    hit_dir_hi ? dir_hi_ff :
    hit_lvl_lo ? lvl_view[15:0] :
    hit_lvl_hi ? lvl_view[31:16] :
    gpio_pkg::RD_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  // mode and direction registers; reset gives only codes 00 and 01
  always_ff @(posedge clk) begin
    if (rst) begin
      fsel_lo_ff <= gpio_pkg::RST_FSEL_LO;
      fsel_hi_ff <= gpio_pkg::RST_FSEL_HI;
      dir_lo_ff <= gpio_pkg::RST_DIR_LO;
      dir_hi_ff <= gpio_pkg::RST_DIR_HI;
    end else begin
      if (wr_en && hit_fsel_lo) fsel_lo_ff <= wr_data;
      if (wr_en && hit_fsel_hi) fsel_hi_ff <= wr_data;
      if (wr_en && hit_dir_lo) dir_lo_ff <= wr_data;
      if (wr_en && hit_dir_hi) dir_hi_ff <= wr_data;
    end
  end

  // level latch; written even while pins are inputs so a later switch is glitch-free
  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_lo_ff <= gpio_pkg::RST_LVL;
      lvl_hi_ff <= gpio_pkg::RST_LVL;
    end else begin
      if (wr_en && hit_lvl_lo) lvl_lo_ff <= wr_data;
      if (wr_en && hit_lvl_hi) lvl_hi_ff <= wr_data;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= gpio_pkg::RD_IDLE;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= gpio_pkg::RD_IDLE;
    end
  end

  // registered pad controls; costs one cycle but keeps pads glitch-free
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_ff <= gpio_pkg::PIN_ZERO;
      pin_oe_ff <= gpio_pkg::PIN_ZERO;
      pull_up_ff <= gpio_pkg::PIN_ZERO;
      pull_dn_ff <= gpio_pkg::PIN_ZERO;
      func_in_ff <= gpio_pkg::PIN_ZERO;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pull_up_ff <= nxt_pull_up;
      pull_dn_ff <= nxt_pull_dn;
      func_in_ff <= pin_in;
    end
  end

  // outputs straight from flops
  assign rd_data = rd_data_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign pull_up_en = pull_up_ff;
  assign pull_down_en = pull_dn_ff;
  assign func_in = func_in_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // reset leaves every pin in code 00 or 01
  a_reset_codes: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> ((mode_all & ~dir_all) == gpio_pkg::PIN_ZERO) && (mode_all == gpio_pkg::PIN_ZERO))
    else $error("pin left reset outside codes 00 and 01");

  a_upper_reset: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> fsel_hi_ff == gpio_pkg::RST_FSEL_HI && dir_hi_ff == gpio_pkg::RST_DIR_HI)
    else $error("upper mode or direction reset value wrong");

  a_lower_reset: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> fsel_lo_ff == gpio_pkg::RST_FSEL_LO && dir_lo_ff == gpio_pkg::RST_DIR_LO)
    else $error("lower mode or direction reset value wrong");

  // drive enable follows mode and direction one cycle later
  a_oe_decode: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> pin_oe_ff == $past((mode_all & ~dir_all) | (~mode_all & ~dir_all & func_oe)))
    else $error("output enable does not match mode and direction");

  // driven level is the stored bit, not inverted
  a_out_level: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> ((pin_out_ff ^ $past(lvl_all)) & $past(mode_all & ~dir_all)) == 32'h0)
    else $error("output pin level differs from stored bit");

  // a read of the lower level register returns input pads as they were
  a_input_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_en && hit_lvl_lo |=> ((rd_data_ff ^ $past(pin_in[15:0])) & $past(dir_lo_ff)) == 16'h0)
    else $error("input level read back wrong");

  // a direction write shows on the pads two edges later
  a_dir_to_pad: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit_dir_lo |-> ##2
      (((pin_oe_ff[15:0] ^ ~$past(wr_data, 2)) & $past(fsel_lo_ff)) == 16'h0))
    else $error("direction write did not reach pads in time");

  // pulls only in the pulled-input code, polarity per mask
  a_pull_sel: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> (pull_up_ff | pull_dn_ff) == $past(~mode_all & dir_all)
      && (pull_dn_ff & ~gpio_pkg::PULL_DOWN_MASK) == 32'h0)
    else $error("pull enables wrong");

  // read data return zero outside a read cycle
  a_read_idle: assert property (
    @(posedge clk) disable iff (rst)
    !rd_en |=> rd_data_ff == gpio_pkg::RD_IDLE)
    else $error("read data outside a read cycle");

  // peripherals see the pad one cycle late, through the func_in_ff copy; reset loads zero
  a_func_in_copy: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> func_in_ff == $past(pin_in))
    else $error("peripheral input copy wrong");

  // a register write lands on the very next edge
  a_fsel_lo_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit_fsel_lo |=> fsel_lo_ff == $past(wr_data))
    else $error("lower mode write lost");

  a_fsel_hi_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit_fsel_hi |=> fsel_hi_ff == $past(wr_data))
    else $error("upper mode write lost");

  a_dir_hi_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit_dir_hi |=> dir_hi_ff == $past(wr_data))
    else $error("upper direction write lost");

  // level bits are stored even for input pins, so a later switch is clean
  a_lvl_hi_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit_lvl_hi |=> lvl_hi_ff == $past(wr_data))
    else $error("upper level write lost");

  // without a write strobe no register may move
  a_reg_hold: assert property (
    @(posedge clk) disable iff (rst)
    !wr_en |=> $stable(fsel_lo_ff) && $stable(dir_lo_ff) && $stable(lvl_lo_ff)
      && $stable(fsel_hi_ff) && $stable(dir_hi_ff) && $stable(lvl_hi_ff))
    else $error("register changed without a write");

  // reads return the stored mode and direction words
  a_read_fsel: assert property (
    @(posedge clk) disable iff (rst)
    rd_en && hit_fsel_lo |=> rd_data_ff == $past(fsel_lo_ff))
    else $error("lower mode read back wrong");

  a_read_dir: assert property (
    @(posedge clk) disable iff (rst)
    rd_en && hit_dir_hi |=> rd_data_ff == $past(dir_hi_ff))
    else $error("upper direction read back wrong");

  // non-input pins read back the stored bit, input pins the pad
  a_level_stored: assert property (
    @(posedge clk) disable iff (rst)
    rd_en && hit_lvl_hi |=> ((rd_data_ff ^ $past(lvl_hi_ff)) & ~$past(dir_hi_ff)) == 16'h0)
    else $error("upper stored level read back wrong");

  a_input_read_hi: assert property (
    @(posedge clk) disable iff (rst)
    rd_en && hit_lvl_hi |=> ((rd_data_ff ^ $past(pin_in[31:16])) & $past(dir_hi_ff)) == 16'h0)
    else $error("upper input level read back wrong");

  // normal code hands the pad to the peripheral, level included
  a_normal_pass: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |->
      ((pin_out_ff ^ $past(func_out)) & $past(~mode_all & ~dir_all & func_oe)) == 32'h0)
    else $error("normal pin does not follow its peripheral");

  // code 11 must neither drive nor pull, or external levels get loaded
  a_bare_input: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |->
      (((pin_oe_ff | pull_up_ff | pull_dn_ff) & $past(mode_all & dir_all)) == 32'h0))
    else $error("bare input pin drives or pulls");

endmodule

`default_nettype wire

// *** gpio_board.sv ***
`timescale 1ns/1ps
`default_nettype none

module gpio_board (
  // clock
  input wire logic clk,
  // pad side of the block
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pull_up_en,
  input wire logic [31:0] pull_down_en,
  // external drivers on the board
  input wire logic [31:0] ext_drv,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  logic [31:0] float_ff = 32'h0000_0000;

  // an undriven, unpulled pad wanders so a stale level never reads as valid
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  // block drive wins, then the board, then the weak pulls
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
    | (~pin_oe & ~ext_drv & (pull_up_en | (~pull_down_en & float_ff)));
endmodule

`default_nettype wire

// *** gpio_pins_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module gpio_pins_tb;
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] r;} gpio_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] func_out = 32'h1234_5678;
  logic [31:0] func_oe = 32'hff00_ff00;
  logic [31:0] ext_drv = 32'h0000_0000;
  logic [31:0] ext_val = 32'h5a5a_c3c3;
  logic [15:0] rd_data;
  logic [31:0] func_in, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [15:0] v;
  logic [31:0] m, d, l, e_oe, e_lv;
  int num_errors = 0;
  int samples_checked = 0;
  // unmapped rows must read back zero
  gpio_row_t rows [6] = '{'{8'h70, 16'ha5a5, 16'ha5a5}, '{8'h72, 16'h5a5a, 16'h5a5a},
    '{8'h76, 16'hc3c3, 16'hc3c3}, '{8'h78, 16'h3c3c, 16'h3c3c},
    '{8'h7c, 16'hffff, 16'h0000}, '{8'h71, 16'hffff, 16'h0000}};

  gpio_pins dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .func_out(func_out), .func_oe(func_oe),
    .func_in(func_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
  gpio_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  initial begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pad(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk);
    addr <= a;
    wr_data <= w;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // expected pads from mode m, direction d, level l
  task automatic check_pads;
    e_oe = (~m & ~d & func_oe) | (m & ~d);
    chk_pad(pin_oe, e_oe);
    chk_pad(pin_out & e_oe, ((~m & ~d & func_out) | (m & ~d & l)) & e_oe);
    chk_pad(pull_up_en, ~m & d & ~gpio_pkg::PULL_DOWN_MASK);
    chk_pad(pull_down_en, ~m & d & gpio_pkg::PULL_DOWN_MASK);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    m = 32'h0000_0000;
    d = {gpio_pkg::RST_DIR_HI, gpio_pkg::RST_DIR_LO};
    l = 32'h0000_0000;
    check_pads;
    rd(8'h70);
    chk_reg(v, 16'h0000);
    rd(8'h72);
    chk_reg(v, 16'hfc0f);
    rd(8'h76);
    chk_reg(v, 16'h0000);
    rd(8'h78);
    chk_reg(v, 16'hffff);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk_reg(v, rows[i].r);
    end
    $display("test register table done");
    // each nibble holds all four codes, in opposite order high and low
    m = {16'h3333, 16'hcccc};
    d = {16'h5555, 16'haaaa};
    l = {16'h0ff0, 16'hf0f0};
    ext_drv <= d;
    wr(8'h70, m[15:0]);
    wr(8'h76, m[31:16]);
    wr(8'h72, d[15:0]);
    wr(8'h78, d[31:16]);
    wr(8'h74, l[15:0]);
    wr(8'h7a, l[31:16]);
    @(posedge clk);
    #1;
    check_pads;
    chk_pad(func_in & d, ext_val & d);
    e_lv = (l & ~d) | (ext_val & d);
    rd(8'h74);
    chk_reg(v, e_lv[15:0]);
    rd(8'h7a);
    chk_reg(v, e_lv[31:16]);
    $display("test pin decode done");
    // open drain on pin 0: level held low, direction carries the data
    ext_drv <= 32'h0000_0000;
    wr(8'h72, 16'h0001);
    wr(8'h70, 16'h0001);
    wr(8'h74, 16'h0000);
    wr(8'h72, 16'h0000);
    #1;
    chk_pad({31'h0, pin_oe[0]}, 32'h0000_0000);
    @(posedge clk);
    #1;
    chk_pad({31'h0, pin_oe[0]}, 32'h0000_0001);
    chk_pad({31'h0, pin_in[0]}, 32'h0000_0000);
    wr(8'h72, 16'h0001);
    @(posedge clk);
    #1;
    chk_pad({31'h0, pin_oe[0]}, 32'h0000_0000);
    $display("test open drain done");
    // reset again mid-run; pulled inputs must read high with no board drive
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    m = 32'h0000_0000;
    d = {gpio_pkg::RST_DIR_HI, gpio_pkg::RST_DIR_LO};
    check_pads;
    rd(8'h70);
    chk_reg(v, 16'h0000);
    rd(8'h74);
    chk_reg(v & gpio_pkg::RST_DIR_LO, gpio_pkg::RST_DIR_LO);
    rd(8'h7a);
    chk_reg(v, gpio_pkg::RST_DIR_HI);
    $display("test mid-run reset done");
    final_report;
  end

  // the tests need well under 400 cycles
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule

`default_nettype wire
